// file: hw/aclk_ctrl.sv
// Clock source selection, system divider and low-power control registers
// Function
// RQ1 - Slow system clock switch set moves system clock to 32 kHz; clear returns to 16 MHz.
// RQ2 - Low-power select and configuration registers take writes only while key unlocked.
// RQ3 - Key value 0xC59D6 unlocks low-power registers; any other value relocks them.
// RQ4 - Configuration bit 8 powers down the analog regulator; resets to one.
// RQ5 - Bit 7 enables common-mode buffer, bit 6 reference buffer; both reset zero.
// RQ6 - Bit 2 enables conversions, bit 3 repeated conversions; both reset zero.
// RQ7 - Bit 1 powers down the fast reference; resets to one.
// RQ8 - Bit 0 powers down the fast oscillator; resets to zero.
// RQ9 - Sleep and wake-up timer runs from the 32 kHz internal oscillator.
// RQ10 - Software uses 32 MHz oscillator setting only for wide-band measurements.
// RQ11 - With 32 MHz root, software programs divider two for 16 MHz logic.
// RQ12 - ADC clock bypasses the system divider.
// RQ13 - External clock on a general pin is an alternative root source.
// RQ14 - After reset the fast internal oscillator drives the system clock.
// RQ15 - Divider register accepts an update only after key 0xA815 is written.
// RQ16 - System clock is root divided by field; 0 and 1 give one, above 32 saturate.
// RQ17 - Software leaves upper divider bits alone; they reset to 0x11.
// RQ18 - Software keeps system clock at 16 MHz for validated performance.
// RQ19 - Source and divider changes are glitch-free, taking effect at period boundary; code switches the ADC source (select bits 3:2) at once.
`timescale 1ns/100ps
`include "aclk_defs.svh"

module aclk_ctrl
  import aclk_pkg::*;
(
  // Clock and reset
  input  wire logic           mclk,
  input  wire logic           reset,
  // Wishbone slave
  input  wire logic           wb_cyc_i,
  input  wire logic           wb_stb_i,
  input  wire logic           wb_we_i,
  input  wire logic [15:0]    wb_adr_i,
  input  wire logic [3:0]     wb_sel_i,
  input  wire logic [31:0]    wb_dat_i,
  output logic      [31:0]    wb_dat_o,
  output logic                wb_ack_o,
  // Oscillator and clock pins
  input  wire logic           fast_osc_clk,
  input  wire logic           xtal_clk,
  input  wire logic           slow_osc_clk,
  input  wire logic           ext_clk_pin,
  // Clock enables out
  output logic                sys_clk_en,
  output logic                adc_clk_en,
  output logic                timer_clk_en,
  // Analog control
  output aclk_power_type      power_ctrl,
  output logic [15:0]         gate_ctrl,
  output logic [15:0]         osc_ctrl,
  output logic [15:0]         fast_osc_cfg,
  output logic [15:0]         slow_osc_trim
);

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0]  sel);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  function automatic logic [5:0] eff_div(input logic [15:0] div_val);
    logic [5:0] res;
    res = div_val[`ACLK_DIV_MSB:0];
    if (res < `ACLK_DIV_ONE) begin
      res = `ACLK_DIV_ONE; // RQ16
    end else if (res > `ACLK_DIV_MAX) begin
      res = `ACLK_DIV_MAX; // RQ16
    end
    return res;
  endfunction : eff_div

  //////////////////////////////////////////////////////////////////////////////
  // State

  aclk_state_type state_reg;
  aclk_state_type state_next;
  logic [3:0]     src_edge;
  logic           bus_req;
  logic           wr_req;
  logic           lp_open;
  logic [31:0]    wmerge;
  aclk_src_type   want_src;
  aclk_src_type   adc_src;
  logic [5:0]     cnt_inc;

  assign src_edge = state_reg.sync2 & ~state_reg.sync3;
  assign bus_req  = wb_cyc_i & wb_stb_i & ~state_reg.ack;
  assign wr_req   = bus_req & wb_we_i;
  assign lp_open  = (state_reg.lpkey_reg == `ACLK_KEY_LP); // RQ3

  always_comb begin
    state_next = state_reg;
    wmerge     = merge_bytes(32'h0000_0000, wb_dat_i, wb_sel_i);
    cnt_inc    = state_reg.cnt + 6'h01;

    // Pin synchronisers, edge taken between second and third stage
    state_next.sync1 = {ext_clk_pin, slow_osc_clk, xtal_clk, fast_osc_clk}; // RQ13
    state_next.sync2 = state_reg.sync1;
    state_next.sync3 = state_reg.sync2;

    ////////////////////////////////////////////////////////////////////////////
    // System source and divider, switched only at the end of a system period; ADC source switched at once
    if (state_reg.lpsel_reg[`ACLK_SLOW_BIT]) begin
      want_src = SRC_SLOW; // RQ1
    end else begin
      want_src = aclk_src_type'(state_reg.sel_reg[`ACLK_SYSSEL_LSB +: 2]); // RQ1
    end
    adc_src = aclk_src_type'(state_reg.sel_reg[`ACLK_ADCSEL_LSB +: 2]);

    state_next.sys_en = 1'b0;
    if (src_edge[state_reg.act_src]) begin
      if (cnt_inc >= state_reg.act_div) begin
        state_next.sys_en  = 1'b1; // RQ16
        state_next.cnt     = 6'h00;
        state_next.act_src = want_src; // RQ19
        state_next.act_div = eff_div(state_reg.div_reg); // RQ19
      end else begin
        state_next.cnt = cnt_inc;
      end
    end
    state_next.adc_en   = src_edge[adc_src]; // RQ12
    state_next.timer_en = src_edge[SRC_SLOW] &
                          ~state_reg.chop_reg[`ACLK_TIMER_DIS_BIT]; // RQ9

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone slave: one-cycle registered acknowledge
    state_next.ack   = bus_req;
    state_next.rdata = 32'h0000_0000;
    if (bus_req && !wb_we_i) begin
      if (wb_adr_i == `ACLK_OFS_DIV) begin
        state_next.rdata = {16'h0000, state_reg.div_reg};
      end else if (wb_adr_i == `ACLK_OFS_GATE) begin
        state_next.rdata = {16'h0000, state_reg.gate_reg};
      end else if (wb_adr_i == `ACLK_OFS_SEL) begin
        state_next.rdata = {16'h0000, state_reg.sel_reg};
      end else if (wb_adr_i == `ACLK_OFS_OSCILLATOR_UNLOCK_KEY) begin
        state_next.rdata = {16'h0000, state_reg.oscillator_unlock_key_reg};
      end else if (wb_adr_i == `ACLK_OFS_OSCILLATOR_CONTROL) begin
        state_next.rdata = {16'h0000, state_reg.oscillator_control_reg};
      end else if (wb_adr_i == `ACLK_OFS_LOSC) begin
        state_next.rdata = {16'h0000, state_reg.losc_reg};
      end else if (wb_adr_i == `ACLK_OFS_CHOP) begin
        state_next.rdata = {16'h0000, state_reg.chop_reg};
      end else if (wb_adr_i == `ACLK_OFS_HSOSC) begin
        state_next.rdata = {16'h0000, state_reg.hsosc_reg};
      end else if (wb_adr_i == `ACLK_OFS_LPKEY) begin
        state_next.rdata = {12'h000, state_reg.lpkey_reg};
      end else if (wb_adr_i == `ACLK_OFS_LPSEL) begin
        state_next.rdata = state_reg.lpsel_reg;
      end else if (wb_adr_i == `ACLK_OFS_LPCON) begin
        state_next.rdata = state_reg.lpcon_reg;
      end else begin
        state_next.rdata = 32'h0000_0000;
      end
    end

    if (wr_req) begin
      if (wb_adr_i == `ACLK_OFS_DIVKEY) begin
        state_next.div_armed = (wmerge[15:0] == `ACLK_KEY_DIV); // RQ15
      end else if (wb_adr_i == `ACLK_OFS_DIV) begin
        if (state_reg.div_armed) begin
          state_next.div_reg =
            16'(merge_bytes({16'h0000, state_reg.div_reg}, wb_dat_i, wb_sel_i)); // RQ15
        end
        state_next.div_armed = 1'b0; // RQ15
      end else if (wb_adr_i == `ACLK_OFS_GATE) begin
        state_next.gate_reg =
          16'(merge_bytes({16'h0000, state_reg.gate_reg}, wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == `ACLK_OFS_SEL) begin
        state_next.sel_reg =
          16'(merge_bytes({16'h0000, state_reg.sel_reg}, wb_dat_i, wb_sel_i))
          & `ACLK_SEL_MASK;
      end else if (wb_adr_i == `ACLK_OFS_OSCILLATOR_UNLOCK_KEY) begin
        state_next.oscillator_unlock_key_reg =
          16'(merge_bytes({16'h0000, state_reg.oscillator_unlock_key_reg}, wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == `ACLK_OFS_OSCILLATOR_CONTROL) begin
        state_next.oscillator_control_reg =
          16'(merge_bytes({16'h0000, state_reg.oscillator_control_reg}, wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == `ACLK_OFS_LOSC) begin
        state_next.losc_reg =
          16'(merge_bytes({16'h0000, state_reg.losc_reg}, wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == `ACLK_OFS_CHOP) begin
        state_next.chop_reg =
          16'(merge_bytes({16'h0000, state_reg.chop_reg}, wb_dat_i, wb_sel_i))
          & `ACLK_CHOP_MASK;
      end else if (wb_adr_i == `ACLK_OFS_HSOSC) begin
        state_next.hsosc_reg =
          16'(merge_bytes({16'h0000, state_reg.hsosc_reg}, wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == `ACLK_OFS_LPKEY) begin
        state_next.lpkey_reg =
          20'(merge_bytes({12'h000, state_reg.lpkey_reg}, wb_dat_i, wb_sel_i)); // RQ3
      end else if (wb_adr_i == `ACLK_OFS_LPSEL) begin
        if (lp_open) begin
          state_next.lpsel_reg = merge_bytes(state_reg.lpsel_reg, wb_dat_i, wb_sel_i)
                                 & `ACLK_LPSEL_MASK; // RQ2
        end
      end else if (wb_adr_i == `ACLK_OFS_LPCON) begin
        if (lp_open) begin
          state_next.lpcon_reg = merge_bytes(state_reg.lpcon_reg, wb_dat_i, wb_sel_i)
                                 & `ACLK_LPCON_MASK; // RQ2
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg            <= '0;
      state_reg.div_reg    <= `ACLK_RST_DIV; // RQ17
      state_reg.gate_reg   <= `ACLK_RST_GATE;
      state_reg.oscillator_control_reg <= `ACLK_RST_OSCILLATOR_CONTROL;
      state_reg.losc_reg   <= `ACLK_RST_LOSC;
      state_reg.chop_reg   <= `ACLK_RST_CHOP;
      state_reg.hsosc_reg  <= `ACLK_RST_HSOSC;
      state_reg.lpcon_reg  <= `ACLK_RST_LPCON; // RQ4 RQ5 RQ6 RQ7 RQ8
      state_reg.act_src    <= SRC_FAST; // RQ14
      state_reg.act_div    <= `ACLK_DIV_ONE;
      // Chains start high, so a pin already high gives no false edge
      state_reg.sync1      <= '1;
      state_reg.sync2      <= '1;
      state_reg.sync3      <= '1;
    end else begin
      state_reg <= state_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign wb_ack_o     = state_reg.ack;
  assign wb_dat_o     = state_reg.rdata;
  assign sys_clk_en   = state_reg.sys_en;
  assign adc_clk_en   = state_reg.adc_en;
  assign timer_clk_en = state_reg.timer_en;
  assign gate_ctrl    = state_reg.gate_reg;
  assign osc_ctrl     = state_reg.oscillator_control_reg;
  assign fast_osc_cfg = state_reg.hsosc_reg;
  assign slow_osc_trim = state_reg.losc_reg;

  assign power_ctrl.regulator_pd = state_reg.lpcon_reg[`ACLK_LDO_PD_BIT]; // RQ4
  assign power_ctrl.cm_buf_en    = state_reg.lpcon_reg[`ACLK_CMBUF_BIT]; // RQ5
  assign power_ctrl.ref_buf_en   = state_reg.lpcon_reg[`ACLK_REFBUF_BIT]; // RQ5
  assign power_ctrl.repeat_en    = state_reg.lpcon_reg[`ACLK_REPEAT_BIT]; // RQ6
  assign power_ctrl.conv_en      = state_reg.lpcon_reg[`ACLK_CONV_BIT]; // RQ6
  assign power_ctrl.ref_pd       = state_reg.lpcon_reg[`ACLK_REF_PD_BIT]; // RQ7
  assign power_ctrl.fast_osc_pd  = state_reg.lpcon_reg[`ACLK_OSC_PD_BIT]; // RQ8

endmodule : aclk_ctrl

// file: hw/aclk_defs.svh
// Register map, reset values, keys and field positions of the clock control block
`ifndef ACLK_DEFS_SVH
`define ACLK_DEFS_SVH
`define ACLK_OFS_DIV      16'h0408
`define ACLK_OFS_GATE     16'h0410
`define ACLK_OFS_SEL      16'h0414
`define ACLK_OFS_DIVKEY   16'h0420
`define ACLK_OFS_OSCILLATOR_UNLOCK_KEY   16'h0a0c
`define ACLK_OFS_OSCILLATOR_CONTROL   16'h0a10
`define ACLK_OFS_RSTKEY   16'h0a5c
`define ACLK_OFS_LOSC     16'h0a6c
`define ACLK_OFS_CHOP     16'h0a70
`define ACLK_OFS_HSOSC    16'h20bc
`define ACLK_OFS_LPKEY    16'h210c
`define ACLK_OFS_LPSEL    16'h2110
`define ACLK_OFS_LPCON    16'h2114
`define ACLK_RST_DIV      16'h0441
`define ACLK_RST_GATE     16'h01c0
`define ACLK_RST_OSCILLATOR_CONTROL   16'h0003
`define ACLK_RST_LOSC     16'h0088
`define ACLK_RST_CHOP     16'h0004
`define ACLK_RST_HSOSC    16'h0034
`define ACLK_RST_LPCON    32'h0000_0102
`define ACLK_KEY_LP       20'hc59d6
`define ACLK_KEY_DIV      16'ha815
`define ACLK_LPSEL_MASK   32'h0000_0001
`define ACLK_LPCON_MASK   32'h0000_01ff
`define ACLK_LPKEY_MASK   32'h000f_ffff
`define ACLK_SEL_MASK     16'h000f
`define ACLK_CHOP_MASK    16'h0007
`define ACLK_DIV_MSB      5
`define ACLK_DIV_MAX      6'h20
`define ACLK_DIV_ONE      6'h01
`define ACLK_SYSSEL_LSB   0
`define ACLK_ADCSEL_LSB   2
`define ACLK_SLOW_BIT     0
`define ACLK_LDO_PD_BIT   8
`define ACLK_CMBUF_BIT    7
`define ACLK_REFBUF_BIT   6
`define ACLK_REPEAT_BIT   3
`define ACLK_CONV_BIT     2
`define ACLK_REF_PD_BIT   1
`define ACLK_OSC_PD_BIT   0
`define ACLK_TIMER_DIS_BIT 1
`endif

// file: hw/aclk_pkg.sv
// Types shared by the clock control block
package aclk_pkg;
  typedef enum logic [1:0] {SRC_FAST, SRC_XTAL, SRC_SLOW, SRC_EXT} aclk_src_type;

  typedef struct packed {
    logic regulator_pd;
    logic cm_buf_en;
    logic ref_buf_en;
    logic repeat_en;
    logic conv_en;
    logic ref_pd;
    logic fast_osc_pd;
  } aclk_power_type;

  typedef struct packed {
    logic [15:0]  div_reg;
    logic [15:0]  gate_reg;
    logic [15:0]  sel_reg;
    logic [15:0]  oscillator_unlock_key_reg;
    logic [15:0]  oscillator_control_reg;
    logic [15:0]  losc_reg;
    logic [15:0]  chop_reg;
    logic [15:0]  hsosc_reg;
    logic [31:0]  lpsel_reg;
    logic [31:0]  lpcon_reg;
    logic [19:0]  lpkey_reg;
    logic         div_armed;
    logic [3:0]   sync1;
    logic [3:0]   sync2;
    logic [3:0]   sync3;
    aclk_src_type act_src;
    logic [5:0]   act_div;
    logic [5:0]   cnt;
    logic         sys_en;
    logic         adc_en;
    logic         timer_en;
    logic         ack;
    logic [31:0]  rdata;
  } aclk_state_type;
endpackage : aclk_pkg

// file: tb/aclk_ctrl_asserts.sv
// Port-level assertions for the clock control block
`timescale 1ns/100ps
module aclk_ctrl_asserts
  import aclk_pkg::*;
(
  // Clock and reset
  input wire logic           mclk,
  input wire logic           reset,
  // Wishbone slave
  input wire logic           wb_cyc_i,
  input wire logic           wb_stb_i,
  input wire logic           wb_we_i,
  input wire logic [15:0]    wb_adr_i,
  input wire logic [3:0]     wb_sel_i,
  input wire logic [31:0]    wb_dat_i,
  input wire logic [31:0]    wb_dat_o,
  input wire logic           wb_ack_o,
  // Enables and analog control
  input wire logic           sys_clk_en,
  input wire logic           adc_clk_en,
  input wire aclk_power_type power_ctrl,
  input wire logic [15:0]    gate_ctrl
);
////////////////////////////////////////////////////////////////////////////////
  logic       take;
  logic       key_ok;
  logic [6:0] pw_exp;
  assign take   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign pw_exp = {wb_dat_i[8:6], wb_dat_i[3:0]};
  // Mirror of the low-power key state
  always_ff @(posedge mclk) begin
    if (reset) key_ok <= 1'b0;
    else if (take && wb_we_i && wb_adr_i == 16'h210c) key_ok <= wb_dat_i[19:0] == 20'hc59d6;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
////////////////////////////////////////////////////////////////////////////////
  a_ack_answer: assert property (take |=> wb_ack_o) else $error("ack missing");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data not zero");
  a_key_reads_zero: assert property (take && !wb_we_i && wb_adr_i == 16'h0420
    |=> wb_dat_o == 32'h0) else $error("key readable");
  a_lp_locked: assert property (take && wb_we_i && wb_adr_i == 16'h2114 && !key_ok
    |=> $stable(power_ctrl)) else $error("locked write taken");
  a_lp_written: assert property (take && wb_we_i && wb_adr_i == 16'h2114 && key_ok
    |=> power_ctrl == $past(pw_exp)) else $error("unlocked write lost");
  a_gate_written: assert property (take && wb_we_i && wb_adr_i == 16'h0410
    |=> gate_ctrl == $past(wb_dat_i[15:0])) else $error("gate write lost");
  a_sys_pulse: assert property (sys_clk_en |=> !sys_clk_en) else $error("sys tick too long");
  // Checked through reset itself, so the default disable is overridden
  a_reset_power: assert property (@(posedge mclk) disable iff (1'b0) reset
    |=> power_ctrl == 7'h42 && !sys_clk_en && !adc_clk_en) else $error("bad reset state");
endmodule : aclk_ctrl_asserts
bind aclk_ctrl aclk_ctrl_asserts i_aclk_ctrl_asserts (.mclk(mclk), .reset(reset),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .sys_clk_en(sys_clk_en), .adc_clk_en(adc_clk_en), .power_ctrl(power_ctrl),
  .gate_ctrl(gate_ctrl));

// file: tb/testbench.sv
// Self-checking testbench for the clock control block
`timescale 1ns/100ps
module testbench
  import aclk_pkg::*;
;
  logic mclk = 0, reset = 1, cyc = 0, stb = 0, we = 0;
  logic [15:0] adr = 0;
  logic [31:0] dat = 0, rd;
  logic fast = 0, xtal = 0, slow = 0, ext = 0;
  logic [31:0] dat_o;
  logic ack, sys_en, adc_en, tmr_en;
  aclk_power_type pwr;
  logic [15:0] gate, osc, hcfg, ltrim, g;
  int failures = 0, total_checks = 0, cycles = 0, ph = 0, i;
  logic [80:0] rows1 [38];
  logic [65:0] rows2 [12];
  aclk_ctrl i_aclk_ctrl (.mclk(mclk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .fast_osc_clk(fast), .xtal_clk(xtal), .slow_osc_clk(slow),
    .ext_clk_pin(ext), .sys_clk_en(sys_en), .adc_clk_en(adc_en), .timer_clk_en(tmr_en),
    .power_ctrl(pwr), .gate_ctrl(gate), .osc_ctrl(osc), .fast_osc_cfg(hcfg),
    .slow_osc_trim(ltrim));
  always #10 mclk = ~mclk;
  // Source clocks: periods of 6, 14, 10 and 8 cycles
  always @(posedge mclk) begin
    ph <= ph + 1;
    fast <= (ph % 6) < 3;
    xtal <= (ph % 14) < 7;
    slow <= (ph % 10) < 5;
    ext <= (ph % 8) < 4;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      results();
    end
  end
////////////////////////////////////////////////////////////////////////////////
  task results();
    if (failures == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task wb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge mclk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge mclk); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask : wb
  function automatic logic pick(input logic [1:0] w);
    return (w == 0) ? sys_en : (w == 1) ? adc_en : tmr_en;
  endfunction : pick
  // Cycles between successive ticks, taken on the third tick
  task gap(input logic [1:0] w);
    for (int k = 0; k < 3; k++) begin
      g = 1;
      @(posedge mclk);
      while (pick(w) !== 1'b1 && g < 700) begin
        @(posedge mclk);
        g++;
      end
    end
  endtask : gap
////////////////////////////////////////////////////////////////////////////////
  initial begin
    rows1 = '{{1'b0,16'h0408,32'h0,32'h441}, {1'b0,16'h0410,32'h0,32'h1c0},
      {1'b0,16'h0414,32'h0,32'h0}, {1'b0,16'h0420,32'h0,32'h0}, {1'b0,16'h0a0c,32'h0,32'h0},
      {1'b0,16'h0a10,32'h0,32'h3}, {1'b0,16'h0a5c,32'h0,32'h0}, {1'b0,16'h0a6c,32'h0,32'h88},
      {1'b0,16'h0a70,32'h0,32'h4}, {1'b0,16'h20bc,32'h0,32'h34}, {1'b0,16'h210c,32'h0,32'h0},
      {1'b0,16'h2110,32'h0,32'h0}, {1'b0,16'h2114,32'h0,32'h102}, {1'b0,16'h0100,32'h0,32'h0},
      {1'b1,16'h0100,32'hdead,32'h0}, {1'b1,16'h2114,32'h1c5,32'h0},
      {1'b0,16'h2114,32'h0,32'h102}, {1'b1,16'h210c,32'hc59d6,32'h0},
      {1'b1,16'h2114,32'h1c5,32'h0}, {1'b0,16'h2114,32'h0,32'h1c5},
      {1'b1,16'h2110,32'h1,32'h0}, {1'b0,16'h2110,32'h0,32'h1}, {1'b1,16'h2110,32'h0,32'h0},
      {1'b1,16'h210c,32'h0,32'h0}, {1'b1,16'h2114,32'h0,32'h0}, {1'b0,16'h2114,32'h0,32'h1c5},
      {1'b1,16'h0408,32'h43,32'h0}, {1'b0,16'h0408,32'h0,32'h441},
      {1'b1,16'h0420,32'ha815,32'h0}, {1'b1,16'h0408,32'h442,32'h0},
      {1'b0,16'h0408,32'h0,32'h442}, {1'b1,16'h0408,32'h443,32'h0},
      {1'b0,16'h0408,32'h0,32'h442}, {1'b1,16'h0410,32'h1234,32'h0},
      {1'b0,16'h0410,32'h0,32'h1234}, {1'b1,16'h0a70,32'hffff,32'h0},
      {1'b0,16'h0a70,32'h0,32'h7}, {1'b1,16'h0a70,32'h4,32'h0}};
    rows2 = '{{16'h0,32'h0,2'd0,16'd12}, {16'h0,32'h0,2'd1,16'd6}, {16'h0,32'h0,2'd2,16'd10},
      {16'h0408,32'h400,2'd0,16'd6}, {16'h0408,32'h463,2'd0,16'd192},
      {16'h0408,32'h441,2'd0,16'd6},
      {16'h0414,32'h3,2'd0,16'd8}, {16'h0414,32'hc,2'd1,16'd8}, {16'h0414,32'h5,2'd1,16'd14},
      {16'h0408,32'h442,2'd0,16'd28},
      {16'h210c,32'hc59d6,2'd3,16'd0}, {16'h2110,32'h1,2'd0,16'd20}};
    repeat (6) @(posedge mclk);
    reset <= 0;
    for (i = 0; i < 38; i++) begin
      wb(rows1[i][80], rows1[i][79:64], rows1[i][63:32]);
      if (!rows1[i][80]) chk("register", rd, rows1[i][31:0]);
    end
    chk("power_ctrl", 32'(pwr), 32'h75);
    chk("gate_ctrl", 32'(gate), 32'h1234);
    wb(1'b1, 16'h0a10, 32'h5a5a);
    wb(1'b1, 16'h20bc, 32'h1357);
    wb(1'b1, 16'h0a6c, 32'h2468);
    chk("osc_ctrl", 32'(osc), 32'h5a5a);
    chk("fast_osc_cfg", 32'(hcfg), 32'h1357);
    chk("slow_osc_trim", 32'(ltrim), 32'h2468);
    for (i = 0; i < 12; i++) begin
      if (rows2[i][65:50] == 16'h0408) wb(1'b1, 16'h0420, 32'ha815);
      if (rows2[i][65:50] != 16'h0) wb(1'b1, rows2[i][65:50], rows2[i][49:18]);
      if (rows2[i][17:16] != 2'd3) gap(rows2[i][17:16]);
      if (rows2[i][17:16] != 2'd3)
        chk("tick_gap", 32'(g), 32'(rows2[i][15:0]));
    end
    // Reset in mid-run restores the power-up clocking
    @(posedge mclk);
    reset <= 1;
    repeat (6) @(posedge mclk);
    reset <= 0;
    chk("power_ctrl", 32'(pwr), 32'h42);
    chk("gate_ctrl", 32'(gate), 32'h1c0);
    chk("osc_ctrl", 32'(osc), 32'h3);
    chk("fast_osc_cfg", 32'(hcfg), 32'h34);
    chk("slow_osc_trim", 32'(ltrim), 32'h88);
    wb(1'b0, 16'h2110, 32'h0);
    chk("lpsel", rd, 32'h0);
    gap(2'd0);
    chk("tick_gap", 32'(g), 32'd6);
    results();
  end
endmodule : testbench
